// [rtl/rxopc_pkg.sv]
// shared constants and types for the receive observation path control
package rxopc_pkg;
    // input selector codes for one receive channel
    typedef enum logic [1:0] {
        rxopc_in_port_a,
        rxopc_in_port_b,
        rxopc_in_internal,
        rxopc_in_external
    } rxopc_input_t;

    // loopback kinds requested for tracking calibration
    localparam logic [1:0] LOOP_NONE = 2'h0;
    localparam logic [1:0] LOOP_INTERNAL = 2'h1;
    localparam logic [1:0] LOOP_PRE_AMP = 2'h2;
    localparam logic [1:0] LOOP_POST_AMP = 2'h3;

    // register offsets of the controller
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SLEEP = 8'h04;
    localparam logic [7:0] OFF_DETECT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_OBS = 8'h10;

    // control register field positions
    localparam int CTRL_MON_EN = 0;
    localparam int CTRL_MAIN_B = 1;
    localparam int CTRL_DYN_SW = 2;
    localparam int CTRL_DET_METHOD = 3;
    localparam int CTRL_EXT_DPD = 4;
    localparam int CTRL_CH_SEL = 5;
    localparam int CTRL_CLR_DET = 6;

    // observation register field positions
    localparam int OBS_REQ = 0;
    localparam int OBS_LOOP_LSB = 1;
    localparam int OBS_PREDIST = 3;
    localparam int OBS_CARRIER_HI = 4;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] SLEEP_RESET = 16'h0040;
    localparam logic [15:0] DETECT_RESET = 16'h0010;
    localparam int CNT_W = 16;
endpackage

// [rtl/rxopc_if.sv]
// link between the baseband-side controller and the channel control logic
`timescale 1ns/1ns
`default_nettype none
interface rxopc_if;
    logic mon_en;
    logic [15:0] sleep_len;
    logic [15:0] detect_len;
    logic det_method;
    logic main_port_b;
    logic dyn_switch;
    logic carrier_hi;
    logic ext_dpd;
    logic [1:0] obs_req;
    logic [1:0] loop_kind;
    logic predist;
    logic mon_sleep;
    logic mon_detect;
    logic sig_detected;
    logic [1:0] obs_active;
    logic [1:0] loop_refused;

    modport device (
        input mon_en, sleep_len, detect_len, det_method, main_port_b, dyn_switch,
        input carrier_hi, ext_dpd, obs_req, loop_kind, predist,
        output mon_sleep, mon_detect, sig_detected, obs_active, loop_refused
    );
    modport host (
        output mon_en, sleep_len, detect_len, det_method, main_port_b, dyn_switch,
        output carrier_hi, ext_dpd, obs_req, loop_kind, predist,
        input mon_sleep, mon_detect, sig_detected, obs_active, loop_refused
    );
endinterface
`default_nettype wire

// [rtl/rxopc_channel.sv]
// input selection and observation arbitration for one receive channel
`timescale 1ns/1ns
`default_nettype none
module rxopc_channel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic main_port_b,
    input wire logic dyn_switch,
    input wire logic carrier_hi,
    input wire logic ext_dpd,
    input wire logic monitor_detect,
    // observation request for the own-side transmitter
    input wire logic obs_req,
    input wire logic [1:0] loop_kind,
    input wire logic predist,
    input wire logic rx_busy,
    // results
    output rxopc_pkg::rxopc_input_t input_sel,
    output logic external_loop_pre_amp,
    output logic external_loop_post_amp,
    output logic internal_loopback_path,
    output logic obs_active,
    output logic loop_refused
);
    rxopc_pkg::rxopc_input_t sel_reg, sel_next;
    logic pre_reg, pre_next, post_reg, post_next, ilb_reg, ilb_next;
    logic obs_reg, obs_next, ref_reg, ref_next;
    logic [1:0] kind;

    always_comb begin
        // predistortion forces the post-amp loop; without it, post-amp is used only with ext_dpd
        if (predist) begin
            kind = rxopc_pkg::LOOP_POST_AMP;
        end else if (loop_kind == rxopc_pkg::LOOP_POST_AMP && !ext_dpd) begin
            // without ext_dpd a post-amp request falls back to the internal loop
            kind = rxopc_pkg::LOOP_INTERNAL;
        end else begin
            kind = loop_kind;
        end
        pre_next = 1'b0;
        post_next = 1'b0;
        ilb_next = 1'b0;
        ref_next = 1'b0;
        // observation only while no reception runs: waits, not dropped
        obs_next = obs_req && !rx_busy && !monitor_detect;
        if (dyn_switch) begin
            sel_next = carrier_hi ? rxopc_pkg::rxopc_in_port_b
                                  : rxopc_pkg::rxopc_in_port_a;
        end else begin
            sel_next = main_port_b ? rxopc_pkg::rxopc_in_port_b
                                   : rxopc_pkg::rxopc_in_port_a;
        end
        if (obs_next) begin
            if (kind == rxopc_pkg::LOOP_INTERNAL || kind == rxopc_pkg::LOOP_NONE) begin
                ilb_next = 1'b1;
                sel_next = rxopc_pkg::rxopc_in_internal;
            end else if (dyn_switch) begin
                ref_next = 1'b1;
                obs_next = 1'b0;
            end else begin
                // both external loops share the non-main port, one at a time
                pre_next = (kind == rxopc_pkg::LOOP_PRE_AMP);
                post_next = (kind == rxopc_pkg::LOOP_POST_AMP);
                sel_next = rxopc_pkg::rxopc_in_external;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= rxopc_pkg::rxopc_in_port_a;
            pre_reg <= 1'b0;
            post_reg <= 1'b0;
            ilb_reg <= 1'b0;
            obs_reg <= 1'b0;
            ref_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            pre_reg <= pre_next;
            post_reg <= post_next;
            ilb_reg <= ilb_next;
            obs_reg <= obs_next;
            ref_reg <= ref_next;
        end
    end

    // with ext_dpd the user owns the observer; the device only routes it
    assign input_sel = sel_reg;
    assign external_loop_pre_amp = pre_reg;
    assign external_loop_post_amp = post_reg;
    assign internal_loopback_path = ilb_reg;
    assign obs_active = obs_reg;
    assign loop_refused = ref_reg;
endmodule
`default_nettype wire

// [rtl/rxopc_device.sv]
// device end: monitor sequencer and both receive channels
// Notes on behaviour
// - monitor enabled: loop sleep and detect
// - sleep minimal, leave after sleep interval
// - detect enables receiver, runs detection
// - signal found: exit loop, resume reception
// - nothing found: back to sleep
// - host programs cycle before enabling monitor
// - host should make sleep longer than detect
// - three inputs: internal loop, port a, b
// - one port main, other takes external loop
// - dynamic switching picks port by carrier
// - dynamic switching covers both channels
// - no external loop under dynamic switching
// - never both external loops together
// - channel n observes only transmitter n
// - observe only while reception is idle
// - predistortion uses post-amp loop; with ext_dpd the requested loop is used
// - internal predistortion: device switches roles
// - external predistortion: host owns observer
// - device configures observer gain itself, only without ext_dpd
// - tracking shares time with reception
// - host keeps amplifier off in pre-amp calibration
`timescale 1ns/1ns
`default_nettype none
module rxopc_device (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link to the controller
    rxopc_if.device lnk,
    // radio side status
    input wire logic [1:0] rx_busy,
    input wire logic signal_present,
    // radio side controls
    output logic monitor_rx_enable,
    output logic [1:0] channel1_input,
    output logic [1:0] channel2_input,
    output logic [1:0] external_loop_pre_amp,
    output logic [1:0] external_loop_post_amp,
    output logic [1:0] internal_loopback_path,
    output logic [1:0] observation_gain_auto
);
    typedef enum logic [1:0] {mon_idle, mon_sleep, mon_detect, mon_found} rxopc_mon_t;
    rxopc_mon_t st_reg, st_next;
    logic [rxopc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic det_reg, det_next;
    logic [1:0] obs_act, refused;
    rxopc_pkg::rxopc_input_t sel [2];

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        det_next = det_reg;
        if (!lnk.mon_en) begin
            det_next = 1'b0;
        end
        case (st_reg)
            mon_idle: begin
                if (lnk.mon_en) begin
                    st_next = mon_sleep;
                    cnt_next = lnk.sleep_len;
                end
            end
            mon_sleep: begin
                if (!lnk.mon_en) begin
                    st_next = mon_idle;
                end else if (cnt_reg <= 16'h0001) begin
                    st_next = mon_detect;
                    cnt_next = lnk.detect_len;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            mon_detect: begin
                if (!lnk.mon_en) begin
                    st_next = mon_idle;
                end else if (signal_present) begin
                    st_next = mon_found;
                    det_next = 1'b1;
                end else if (cnt_reg <= 16'h0001) begin
                    st_next = mon_sleep;
                    cnt_next = lnk.sleep_len;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            mon_found: begin
                // normal reception resumes until the host drops the enable
                if (!lnk.mon_en) begin
                    st_next = mon_idle;
                end
            end
            default: st_next = mon_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= mon_idle;
            cnt_reg <= '0;
            det_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            det_reg <= det_next;
        end
    end

    // a single dynamic switch bit feeds both channels
    for (genvar c = 0; c < 2; c++) begin : g_ch
        rxopc_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .main_port_b(lnk.main_port_b),
            .dyn_switch(lnk.dyn_switch),
            .carrier_hi(lnk.carrier_hi),
            .ext_dpd(lnk.ext_dpd),
            .monitor_detect(st_reg == mon_detect && c == 0),
            .obs_req(lnk.obs_req[c]),
            .loop_kind(lnk.loop_kind),
            .predist(lnk.predist && !lnk.ext_dpd),
            .rx_busy(rx_busy[c]),
            .input_sel(sel[c]),
            .external_loop_pre_amp(external_loop_pre_amp[c]),
            .external_loop_post_amp(external_loop_post_amp[c]),
            .internal_loopback_path(internal_loopback_path[c]),
            .obs_active(obs_act[c]),
            .loop_refused(refused[c])
        );
    end

    assign monitor_rx_enable = (st_reg == mon_detect);
    assign channel1_input = sel[0];
    assign channel2_input = sel[1];
    // device sets gain when it owns the observer
    assign observation_gain_auto = obs_act & {2{!lnk.ext_dpd}};
    assign lnk.mon_sleep = (st_reg == mon_sleep);
    assign lnk.mon_detect = (st_reg == mon_detect);
    assign lnk.sig_detected = det_reg;
    assign lnk.obs_active = obs_act;
    assign lnk.loop_refused = refused;
endmodule
`default_nettype wire

// [rtl/rxopc_host.sv]
// host end: apb register block driving the channel control link
`timescale 1ns/1ns
`default_nettype none
module rxopc_host (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to the device
    rxopc_if.host lnk
);
    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] sleep_reg, sleep_next, det_reg, det_next;
    logic [4:0] obs_reg, obs_next;
    logic [31:0] rd_reg, rd_next;
    logic err_reg, err_next;
    logic wr, acc, hit;

    always_comb begin
        acc = psel && !penable;
        // writes commit on the access edge, where the master sees pready high
        wr = psel && penable && pwrite;
        ctrl_next = ctrl_reg;
        sleep_next = sleep_reg;
        det_next = det_reg;
        obs_next = obs_reg;
        rd_next = rd_reg;
        hit = 1'b1;
        case (paddr)
            rxopc_pkg::OFF_CTRL: rd_next = ctrl_reg;
            rxopc_pkg::OFF_SLEEP: rd_next = {16'h0000, sleep_reg};
            rxopc_pkg::OFF_DETECT: rd_next = {16'h0000, det_reg};
            rxopc_pkg::OFF_OBS: rd_next = {27'h0000000, obs_reg};
            rxopc_pkg::OFF_STATUS: rd_next = {25'h0000000, lnk.loop_refused, lnk.obs_active,
                lnk.sig_detected, lnk.mon_detect, lnk.mon_sleep};
            default: begin
                rd_next = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
        err_next = acc ? !hit : err_reg;
        if (!acc) begin
            rd_next = rd_reg;
        end
        if (wr) begin
            // sleep and detect lengths are written only while monitor is off
            if (paddr == rxopc_pkg::OFF_CTRL) begin
                ctrl_next = pwdata;
            end
            if (paddr == rxopc_pkg::OFF_SLEEP && !ctrl_reg[rxopc_pkg::CTRL_MON_EN]) begin
                sleep_next = pwdata[15:0];
            end
            if (paddr == rxopc_pkg::OFF_DETECT && !ctrl_reg[rxopc_pkg::CTRL_MON_EN]) begin
                det_next = pwdata[15:0];
            end
            if (paddr == rxopc_pkg::OFF_OBS) begin
                obs_next = pwdata[4:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= rxopc_pkg::CTRL_RESET;
            sleep_reg <= rxopc_pkg::SLEEP_RESET;
            det_reg <= rxopc_pkg::DETECT_RESET;
            obs_reg <= 5'h00;
            rd_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            sleep_reg <= sleep_next;
            det_reg <= det_next;
            obs_reg <= obs_next;
            rd_reg <= rd_next;
            err_reg <= err_next;
        end
    end

    assign pready = psel && penable;
    assign prdata = rd_reg;
    assign pslverr = psel && penable && err_reg;
    assign lnk.mon_en = ctrl_reg[rxopc_pkg::CTRL_MON_EN];
    assign lnk.main_port_b = ctrl_reg[rxopc_pkg::CTRL_MAIN_B];
    assign lnk.dyn_switch = ctrl_reg[rxopc_pkg::CTRL_DYN_SW];
    assign lnk.det_method = ctrl_reg[rxopc_pkg::CTRL_DET_METHOD];
    assign lnk.ext_dpd = ctrl_reg[rxopc_pkg::CTRL_EXT_DPD];
    assign lnk.sleep_len = sleep_reg;
    assign lnk.detect_len = det_reg;
    // channel select steers the request to its own-side observer
    assign lnk.obs_req = obs_reg[rxopc_pkg::OBS_REQ] ?
        (ctrl_reg[rxopc_pkg::CTRL_CH_SEL] ? 2'h2 : 2'h1) : 2'h0;
    assign lnk.loop_kind = obs_reg[rxopc_pkg::OBS_LOOP_LSB +: 2];
    assign lnk.predist = obs_reg[rxopc_pkg::OBS_PREDIST];
    assign lnk.carrier_hi = obs_reg[rxopc_pkg::OBS_CARRIER_HI];
endmodule
`default_nettype wire

// [bench/rxopc_chk_sva.sv]
// concurrent checks on the link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module rxopc_chk_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // host to device
    input wire logic mon_en,
    input wire logic [15:0] sleep_len,
    input wire logic [15:0] detect_len,
    input wire logic dyn_switch,
    input wire logic [1:0] obs_req,
    // device to host
    input wire logic mon_sleep,
    input wire logic mon_detect,
    input wire logic sig_detected,
    input wire logic [1:0] obs_active,
    input wire logic [1:0] loop_refused
);
    logic [16:0] slp_cnt_reg, slp_cnt_next, det_cnt_reg, det_cnt_next, slp_want, det_want;

    // a zero length still costs one cycle in either state
    always_comb begin
        slp_cnt_next = mon_sleep ? slp_cnt_reg + 17'h1 : 17'h0;
        det_cnt_next = mon_detect ? det_cnt_reg + 17'h1 : 17'h0;
        slp_want = (sleep_len == 16'h0) ? 17'h1 : {1'b0, sleep_len};
        det_want = (detect_len == 16'h0) ? 17'h1 : {1'b0, detect_len};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slp_cnt_reg <= 17'h0;
            det_cnt_reg <= 17'h0;
        end else begin
            slp_cnt_reg <= slp_cnt_next;
            det_cnt_reg <= det_cnt_next;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mon_excl; !(mon_sleep && mon_detect); endproperty
    a_mon_excl: assert property (p_mon_excl) else $error("sleep and detect together");
    property p_mon_start; $rose(mon_en) |=> mon_sleep; endproperty
    a_mon_start: assert property (p_mon_start) else $error("monitor did not start asleep");
    property p_idle; !mon_en && !$past(mon_en) |-> !mon_sleep && !mon_detect && !sig_detected;
    endproperty
    a_idle: assert property (p_idle) else $error("monitor active while disabled");
    property p_sleep_len; $fell(mon_sleep) && mon_detect |-> slp_cnt_reg == slp_want; endproperty
    a_sleep_len: assert property (p_sleep_len) else $error("sleep length wrong");
    property p_sleep_det; $fell(mon_sleep) && $past(mon_en) && mon_en |-> mon_detect; endproperty
    a_sleep_det: assert property (p_sleep_det) else $error("sleep not followed by detect");
    property p_det_len; $fell(mon_detect) && mon_sleep |-> det_cnt_reg == det_want; endproperty
    a_det_len: assert property (p_det_len) else $error("detect length wrong");
    property p_det_back; $fell(mon_detect) && $past(mon_en) && !sig_detected |-> mon_sleep;
    endproperty
    a_det_back: assert property (p_det_back) else $error("empty detect did not sleep");
    property p_found; $rose(sig_detected) |-> $past(mon_detect) && !mon_sleep && !mon_detect;
    endproperty
    a_found: assert property (p_found) else $error("detection did not leave the loop");
    property p_flag_hold; sig_detected && mon_en |=> sig_detected; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("detected flag lost");
    property p_obs_cause; (obs_active & ~$past(obs_req)) == 2'h0; endproperty
    a_obs_cause: assert property (p_obs_cause) else $error("observation without request");
    property p_refuse; loop_refused != 2'h0 |-> $past(dyn_switch); endproperty
    a_refuse: assert property (p_refuse) else $error("loop refused without switching");
    property p_cfg_stable; mon_en && $past(mon_en) |-> $stable(sleep_len) && $stable(detect_len);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("cycle lengths moved");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench joining the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, snap, signal_present, pready, pslverr;
    logic monitor_rx_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic [1:0] rx_busy, channel1_input, channel2_input, external_loop_pre_amp;
    logic [1:0] external_loop_post_amp, internal_loopback_path, observation_gain_auto;
    logic [12:0] port_vec;
    logic [65:0] exp_q[$];
    logic [65:0] mon_e;
    int err_total, cmp_count, cyc;
    localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;

    assign port_vec = {monitor_rx_enable, channel1_input, channel2_input, external_loop_pre_amp,
        external_loop_post_amp, internal_loopback_path, observation_gain_auto};

    rxopc_if i_rxopc_if();
    rxopc_host i_rxopc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(i_rxopc_if.host));
    rxopc_device i_rxopc_device (.pclk(pclk), .presetn(presetn), .lnk(i_rxopc_if.device),
        .rx_busy(rx_busy), .signal_present(signal_present),
        .monitor_rx_enable(monitor_rx_enable), .channel1_input(channel1_input),
        .channel2_input(channel2_input), .external_loop_pre_amp(external_loop_pre_amp),
        .external_loop_post_amp(external_loop_post_amp),
        .internal_loopback_path(internal_loopback_path),
        .observation_gain_auto(observation_gain_auto));
    rxopc_chk_sva i_rxopc_chk_sva (.pclk(pclk), .presetn(presetn), .mon_en(i_rxopc_if.mon_en),
        .sleep_len(i_rxopc_if.sleep_len), .detect_len(i_rxopc_if.detect_len),
        .dyn_switch(i_rxopc_if.dyn_switch), .obs_req(i_rxopc_if.obs_req),
        .mon_sleep(i_rxopc_if.mon_sleep), .mon_detect(i_rxopc_if.mon_detect),
        .sig_detected(i_rxopc_if.sig_detected), .obs_active(i_rxopc_if.obs_active),
        .loop_refused(i_rxopc_if.loop_refused));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // port view of one observing channel; the other keeps the main port
    function automatic logic [12:0] obs_vec(input int ch, input logic [1:0] eff, input logic xd,
        input logic mb, input logic on);
        logic [12:0] v;
        v = {2'h0, mb, 1'b0, mb, 8'h00};
        if (on) begin
            if (eff == rxopc_pkg::LOOP_INTERNAL) v[2 + ch] = 1'b1;
            else if (eff == rxopc_pkg::LOOP_PRE_AMP) v[6 + ch] = 1'b1;
            else v[4 + ch] = 1'b1;
            v[ch] = !xd;
            if (ch == 0) v[11:10] = (eff == rxopc_pkg::LOOP_INTERNAL) ? 2'h2 : 2'h3;
            else v[9:8] = (eff == rxopc_pkg::LOOP_INTERNAL) ? 2'h2 : 2'h3;
        end
        return v;
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (exp_q.size() != 0) err_total++;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m = ALL);
        exp_q.push_back({m, e});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic look(input logic [12:0] e, input logic [12:0] m = 13'h1FFF);
        exp_q.push_back({20'h0, m, 20'h0, e});
        @(posedge pclk);
        snap <= 1'b1;
        @(posedge pclk);
        snap <= 1'b0;
    endtask

    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask

    // results are taken at the edge where they are sampled
    always @(posedge pclk) begin
        if ((psel && penable && pready && !pwrite) || snap) begin
            if (exp_q.size() == 0) err_total++;
            else begin
                mon_e = exp_q.pop_front();
                check((snap ? {20'h0, port_vec} : {pslverr, prdata}) & mon_e[65:33], mon_e[32:0]);
            end
        end
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        int ch;
        logic mb;
        logic [1:0] eff, kd;
        {psel, penable, pwrite, snap, signal_present, presetn} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rx_busy = 2'h0;
        lfsr = 32'hD095;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(rxopc_pkg::OFF_CTRL, {1'b0, rxopc_pkg::CTRL_RESET});
        rd(rxopc_pkg::OFF_SLEEP, {17'h0, rxopc_pkg::SLEEP_RESET});
        rd(rxopc_pkg::OFF_DETECT, {17'h0, rxopc_pkg::DETECT_RESET});
        rd(rxopc_pkg::OFF_STATUS, 33'h0);
        rd(8'h14, 33'h1_0000_0000);
        look(13'h0000);
        // every loop kind, with and without predistortion
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_step(lfsr);
            ch = int'(lfsr[0]);
            mb = lfsr[1];
            kd = 2'(k >> 1);
            eff = k[0] ? rxopc_pkg::LOOP_POST_AMP :
                (kd == rxopc_pkg::LOOP_PRE_AMP) ? kd : rxopc_pkg::LOOP_INTERNAL;
            wr(rxopc_pkg::OFF_CTRL, {26'h0, lfsr[0], 3'h0, mb, 1'b0});
            wr(rxopc_pkg::OFF_OBS, {28'h0, k[0], kd, 1'b1});
            settle();
            look(obs_vec(ch, eff, 1'b0, mb, 1'b1));
            rd(rxopc_pkg::OFF_STATUS, 33'h8 << ch);
            wr(rxopc_pkg::OFF_OBS, 32'h0);
            settle();
            look(obs_vec(ch, eff, 1'b0, mb, 1'b0));
        end
        // a request while receiving waits for the channel to go idle
        wr(rxopc_pkg::OFF_CTRL, {26'h0, lfsr[0], 5'h00});
        rx_busy[ch] <= 1'b1;
        wr(rxopc_pkg::OFF_OBS, 32'h3);
        settle();
        look(obs_vec(ch, rxopc_pkg::LOOP_INTERNAL, 1'b0, 1'b0, 1'b0));
        rx_busy <= 2'h0;
        settle();
        look(obs_vec(ch, rxopc_pkg::LOOP_INTERNAL, 1'b0, 1'b0, 1'b1));
        rx_busy[ch] <= 1'b1;
        settle();
        look(obs_vec(ch, rxopc_pkg::LOOP_INTERNAL, 1'b0, 1'b0, 1'b0));
        rx_busy <= 2'h0;
        wr(rxopc_pkg::OFF_CTRL, {26'h0, lfsr[0], 5'h10});
        // the bench enables no amplifier while the pre-amp loop runs
        wr(rxopc_pkg::OFF_OBS, 32'hD);
        settle();
        look(obs_vec(ch, rxopc_pkg::LOOP_PRE_AMP, 1'b1, 1'b0, 1'b1));
        wr(rxopc_pkg::OFF_OBS, 32'h0);
        // dynamic switching moves both channels and refuses external loops
        wr(rxopc_pkg::OFF_CTRL, 32'h4);
        wr(rxopc_pkg::OFF_OBS, 32'h10);
        settle();
        look(13'h0500, 13'h0F00);
        wr(rxopc_pkg::OFF_OBS, 32'h0);
        settle();
        look(13'h0000, 13'h0F00);
        // a pre-amp request, then predistortion forcing the post-amp loop
        for (int k = 5; k < 16; k += 8) begin
            wr(rxopc_pkg::OFF_OBS, 32'(k));
            settle();
            rd(rxopc_pkg::OFF_STATUS, 33'h20, 33'h60);
            look(13'h0000, 13'h00F0);
        end
        wr(rxopc_pkg::OFF_OBS, 32'h0);
        wr(rxopc_pkg::OFF_CTRL, 32'h0);
        // monitor cycle, a refused length write, then a detection
        lfsr = lfsr_step(lfsr);
        // sleep of 12 to 19 cycles stays longer than detect of 4 to 11
        wr(rxopc_pkg::OFF_SLEEP, {29'h0, lfsr[2:0]} + 32'hC);
        wr(rxopc_pkg::OFF_DETECT, {29'h0, lfsr[5:3]} + 32'h4);
        wr(rxopc_pkg::OFF_CTRL, {28'h0, lfsr[6], 3'h1});
        do @(posedge pclk); while (i_rxopc_if.mon_detect !== 1'b1);
        look(13'h1000, 13'h1000);
        do @(posedge pclk); while (i_rxopc_if.mon_sleep !== 1'b1);
        wr(rxopc_pkg::OFF_SLEEP, 32'hFF);
        rd(rxopc_pkg::OFF_SLEEP, {30'h0, lfsr[2:0]} + 33'hC);
        do @(posedge pclk); while (i_rxopc_if.mon_detect !== 1'b1);
        signal_present <= 1'b1;
        do @(posedge pclk); while (i_rxopc_if.sig_detected !== 1'b1);
        signal_present <= 1'b0;
        rd(rxopc_pkg::OFF_STATUS, 33'h4, 33'h7);
        look(13'h0000, 13'h1000);
        wr(rxopc_pkg::OFF_CTRL, 32'h0);
        settle();
        rd(rxopc_pkg::OFF_STATUS, 33'h0, 33'h7);
        // let the watcher take the last read before the verdict
        @(posedge pclk);
        test_done();
    end
endmodule
`default_nettype wire
